// [include/mdl_pkg.sv]
package mdl_pkg;

    // ****************************************
    // register map (byte offsets, 32-bit words)
    // ****************************************
    localparam int ADDR_W = 5;
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_ACT_THR = 5'h04;
    localparam logic [4:0] OFS_ACT_TIME = 5'h08;
    localparam logic [4:0] OFS_INACT_THR = 5'h0C;
    localparam logic [4:0] OFS_INACT_TIME = 5'h10;
    localparam logic [4:0] OFS_IRQ_MAP = 5'h14;
    localparam logic [4:0] OFS_STATUS = 5'h18;
    localparam logic [4:0] OFS_REF = 5'h1C;

    // ****************************************
    // field positions
    // ****************************************
    localparam int CTRL_W = 7;
    localparam int MAP_W = 3;
    localparam int MAP2_POS = 4;
    localparam int STAT_MODE_POS = 3;
    localparam int ACT_TIME_W = 8;
    localparam int INACT_TIME_W = 16;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [CTRL_W-1:0] RST_CTRL = 7'h00;
    localparam logic [ACT_TIME_W-1:0] RST_ACT_TIME = 8'h01;
    localparam logic [INACT_TIME_W-1:0] RST_INACT_TIME = 16'h0001;
    localparam logic [MAP_W-1:0] RST_MAP = 3'h0;

    // control word: loop only counts while link is set
    typedef struct packed {
        logic inact_ref;
        logic act_ref;
        logic autosleep;
        logic loop;
        logic link;
        logic inact_en;
        logic act_en;
    } mdl_ctrl_type;

    // sticky events and awake level, also the irq map layout
    typedef struct packed {
        logic awake;
        logic inact;
        logic act;
    } mdl_evt_type;

    typedef enum logic {
        ST_SEEK_ACT,
        ST_SEEK_INACT
    } mdl_state_type;

endpackage : mdl_pkg

// [design/mdl_link_ctrl.sv]
module mdl_link_ctrl
    import mdl_pkg::*;
#(
    parameter int DATA_W = 12
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic sample_valid,
    input wire logic signed [DATA_W-1:0] sample_data,
    output logic wakeup_mode,
    output logic irq_pin_first,
    output logic irq_pin_second
);

    if (DATA_W < 4 || DATA_W > 24) begin : g_bad_width
        $error("mdl_link_ctrl: DATA_W out of range");
    end

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [DATA_W-1:0] deviation(
        input logic signed [DATA_W-1:0] x,
        input logic signed [DATA_W-1:0] r,
        input logic use_ref
    );
        logic signed [DATA_W:0] d;
        d = {x[DATA_W-1], x};
        if (use_ref) begin
            d = d - {r[DATA_W-1], r};
        end
        if (d[DATA_W]) begin
            d = -d;
        end
        return d[DATA_W-1:0];
    endfunction : deviation

    // ****************************************
    // register bus
    // ****************************************
    mdl_ctrl_type ctrl_q, ctrl_d;
    logic [DATA_W-2:0] act_thr_q, act_thr_d;
    logic [DATA_W-2:0] inact_thr_q, inact_thr_d;
    logic [ACT_TIME_W-1:0] act_time_q, act_time_d;
    logic [INACT_TIME_W-1:0] inact_time_q, inact_time_d;
    logic [MAP_W-1:0] map1_q, map1_d, map2_q, map2_d;
    logic ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic stat_clr;
    logic [2:0] clr_mask;

    mdl_evt_type evt_q, evt_d;
    mdl_state_type st_q, st_d;
    logic wake_q, wake_d;
    logic signed [DATA_W-1:0] ref_q, ref_d;
    logic ref_load_q, ref_load_d;
    logic act_en_q, link_q;
    logic [ACT_TIME_W-1:0] act_cnt_q, act_cnt_d;
    logic [INACT_TIME_W-1:0] inact_cnt_q, inact_cnt_d;

    // one wait state: address decode and read mux settle before the answer
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    assign avs_readdata = rdata_q;

    always_comb begin
        ack_d = (avs_read | avs_write) & ~ack_q;
        rdata_d = rdata_q;
        ctrl_d = ctrl_q;
        act_thr_d = act_thr_q;
        inact_thr_d = inact_thr_q;
        act_time_d = act_time_q;
        inact_time_d = inact_time_q;
        map1_d = map1_q;
        map2_d = map2_q;
        stat_clr = 1'b0;
        clr_mask = rdata_q[2:0];
        if (avs_read && !ack_q) begin
            rdata_d = 32'h0000_0000;
            case (avs_address)
                OFS_CTRL: rdata_d[CTRL_W-1:0] = ctrl_q;
                OFS_ACT_THR: rdata_d[DATA_W-2:0] = act_thr_q;
                OFS_ACT_TIME: rdata_d[ACT_TIME_W-1:0] = act_time_q;
                OFS_INACT_THR: rdata_d[DATA_W-2:0] = inact_thr_q;
                OFS_INACT_TIME: rdata_d[INACT_TIME_W-1:0] = inact_time_q;
                OFS_IRQ_MAP: begin
                    rdata_d[MAP_W-1:0] = map1_q;
                    rdata_d[MAP2_POS+:MAP_W] = map2_q;
                end
                OFS_STATUS: begin
                    rdata_d[2:0] = evt_q;
                    rdata_d[STAT_MODE_POS] = wake_q;
                end
                OFS_REF: rdata_d[DATA_W-1:0] = ref_q;
                default: rdata_d = 32'h0000_0000;
            endcase
        end
        // only the event bits that were returned get cleared
        if (avs_read && ack_q && avs_address == OFS_STATUS) begin
            stat_clr = 1'b1;
        end
        if (avs_write && ack_q) begin
            case (avs_address)
                OFS_CTRL: ctrl_d = avs_writedata[CTRL_W-1:0];
                OFS_ACT_THR: act_thr_d = avs_writedata[DATA_W-2:0];
                OFS_ACT_TIME: act_time_d = avs_writedata[ACT_TIME_W-1:0];
                OFS_INACT_THR: inact_thr_d = avs_writedata[DATA_W-2:0];
                OFS_INACT_TIME:
                    inact_time_d = avs_writedata[INACT_TIME_W-1:0];
                OFS_IRQ_MAP: begin
                    map1_d = avs_writedata[MAP_W-1:0];
                    map2_d = avs_writedata[MAP2_POS+:MAP_W];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            ctrl_q <= RST_CTRL;
            act_thr_q <= '0;
            inact_thr_q <= '0;
            act_time_q <= RST_ACT_TIME;
            inact_time_q <= RST_INACT_TIME;
            map1_q <= RST_MAP;
            map2_q <= RST_MAP;
        end else begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
            ctrl_q <= ctrl_d;
            act_thr_q <= act_thr_d;
            inact_thr_q <= inact_thr_d;
            act_time_q <= act_time_d;
            inact_time_q <= inact_time_d;
            map1_q <= map1_d;
            map2_q <= map2_d;
        end
    end

    // ****************************************
    // detection and linking
    // ****************************************
    logic linked, looped;
    logic act_run, inact_run, act_hit, inact_hit;
    logic act_det, inact_det, sample_ok;
    logic [DATA_W-1:0] act_mag, inact_mag;

    always_comb begin
        linked = ctrl_q.link;
        looped = ctrl_q.link & ctrl_q.loop;
        // a sample that loads the reference is not judged against it
        sample_ok = sample_valid & ~ref_load_q;
        act_mag = deviation(sample_data, ref_q, ctrl_q.act_ref);
        inact_mag = deviation(sample_data, ref_q, ctrl_q.inact_ref);
        act_hit = act_mag > {1'b0, act_thr_q};
        inact_hit = inact_mag < {1'b0, inact_thr_q};
        act_run = ctrl_q.act_en;
        inact_run = ctrl_q.inact_en;
        if (linked) begin
            act_run = ctrl_q.act_en && st_q == ST_SEEK_ACT
                && (looped || !evt_q.inact);
            inact_run = ctrl_q.inact_en && st_q == ST_SEEK_INACT
                && (looped || !evt_q.act);
        end
        act_det = 1'b0;
        inact_det = 1'b0;
        act_cnt_d = act_cnt_q;
        inact_cnt_d = inact_cnt_q;
        if (!act_run) begin
            act_cnt_d = '0;
        end else if (sample_ok) begin
            if (!act_hit) begin
                act_cnt_d = '0;
            end else if (wake_q || act_cnt_q + 1'b1 >= act_time_q) begin
                act_det = 1'b1;
                act_cnt_d = '0;
            end else begin
                act_cnt_d = act_cnt_q + 1'b1;
            end
        end
        if (!inact_run) begin
            inact_cnt_d = '0;
        end else if (sample_ok) begin
            if (!inact_hit) begin
                inact_cnt_d = '0;
            end else if (inact_cnt_q + 1'b1 >= inact_time_q) begin
                inact_det = 1'b1;
                inact_cnt_d = '0;
            end else begin
                inact_cnt_d = inact_cnt_q + 1'b1;
            end
        end

        evt_d = evt_q;
        st_d = st_q;
        wake_d = wake_q;
        ref_d = ref_q;
        ref_load_d = ref_load_q;
        if (ref_load_q && sample_valid) begin
            ref_d = sample_data;
            ref_load_d = 1'b0;
        end
        if (stat_clr) begin
            evt_d.act = evt_q.act & ~clr_mask[0];
            evt_d.inact = evt_q.inact & ~clr_mask[1];
        end
        if (ctrl_q.act_en && !act_en_q) begin
            ref_load_d = 1'b1;
        end
        if (linked && !link_q) begin
            st_d = ST_SEEK_ACT;
            evt_d.awake = 1'b0;
            ref_load_d = 1'b1;
        end
        // events set after any clear, so a set in the clear cycle wins
        if (inact_det) begin
            evt_d.inact = 1'b1;
            evt_d.awake = 1'b0;
            if (linked) begin
                st_d = ST_SEEK_ACT;
                ref_load_d = ref_load_d | ctrl_q.act_ref;
                if (looped) begin
                    evt_d.act = 1'b0;
                end
                if (ctrl_q.autosleep) begin
                    wake_d = 1'b1;
                end
            end
        end
        if (act_det) begin
            evt_d.act = 1'b1;
            evt_d.awake = 1'b1;
            if (linked) begin
                st_d = ST_SEEK_INACT;
                if (looped) begin
                    evt_d.inact = 1'b0;
                end
                if (ctrl_q.autosleep) begin
                    wake_d = 1'b0;
                end
            end else begin
                ref_load_d = ref_load_d | ctrl_q.act_ref;
            end
        end
        // leaving the linked modes drops back to measurement
        if (!linked || !ctrl_q.autosleep) begin
            wake_d = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            evt_q <= '0;
            st_q <= ST_SEEK_ACT;
            wake_q <= 1'b0;
            ref_q <= '0;
            ref_load_q <= 1'b0;
            act_en_q <= 1'b0;
            link_q <= 1'b0;
            act_cnt_q <= '0;
            inact_cnt_q <= '0;
        end else begin
            evt_q <= evt_d;
            st_q <= st_d;
            wake_q <= wake_d;
            ref_q <= ref_d;
            ref_load_q <= ref_load_d;
            act_en_q <= ctrl_q.act_en;
            link_q <= ctrl_q.link;
            act_cnt_q <= act_cnt_d;
            inact_cnt_q <= inact_cnt_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // pins are pure levels from flops; awake gives a motion switch
    assign wakeup_mode = wake_q;
    assign irq_pin_first = |(map1_q & evt_q);
    assign irq_pin_second = |(map2_q & evt_q);

endmodule : mdl_link_ctrl

// [verification/mdl_link_ctrl_monitor.sv]
module mdl_link_ctrl_monitor
    import mdl_pkg::*;
#(
    parameter int DATA_W = 12
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic sample_valid,
    input wire logic wakeup_mode,
    input wire logic irq_pin_first,
    input wire logic irq_pin_second
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    logic done;
    logic done_q;
    logic cause;
    logic touched_q;
    logic link_q;
    logic link_p_q;
    logic auto_q;
    logic auto_p_q;
    assign done = (avs_read | avs_write) & ~avs_waitrequest;
    // entering link clears awake one cycle after the control write lands
    assign cause = sample_valid | done | done_q;
    // shadow of the control word, delayed copy covers a registered output
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            done_q <= 1'b0;
            touched_q <= 1'b0;
            link_q <= 1'b0;
            auto_q <= 1'b0;
            link_p_q <= 1'b0;
            auto_p_q <= 1'b0;
        end else begin
            done_q <= done;
            if (done && avs_write && avs_address == OFS_CTRL) begin
                touched_q <= 1'b1;
                link_q <= avs_writedata[2];
                auto_q <= avs_writedata[4];
            end
            link_p_q <= link_q;
            auto_p_q <= auto_q;
        end
    end
    // ****************************************
    // checks
    // ****************************************
    wait_one_a: assert property (
        (avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    idle_bus_a: assert property (
        !(avs_read | avs_write) |-> !avs_waitrequest)
        else $error("idle wait");
    quiet_rst_a: assert property (
        !touched_q |-> !irq_pin_first && !irq_pin_second && !wakeup_mode)
        else $error("early event");
    dflt_wake_a: assert property (
        !link_q && !link_p_q |-> !wakeup_mode)
        else $error("sleep in default");
    no_auto_a: assert property (
        !auto_q && !auto_p_q |-> !wakeup_mode)
        else $error("sleep without autosleep");
    pin1_cause_a: assert property (
        $changed(irq_pin_first) |-> $past(cause))
        else $error("pin1 moved");
    pin2_cause_a: assert property (
        $changed(irq_pin_second) |-> $past(cause))
        else $error("pin2 moved");
    wake_cause_a: assert property (
        $changed(wakeup_mode) && link_p_q && auto_p_q |-> $past(sample_valid))
        else $error("mode moved");
    rd_hold_a: assert property (
        $changed(avs_readdata) |-> $past(avs_read))
        else $error("readdata moved");
    cover property (sample_valid ##1 $rose(irq_pin_first));
    cover property ($rose(wakeup_mode));
    cover property ($fell(wakeup_mode));
    cover property (done && avs_read);
endmodule : mdl_link_ctrl_monitor

bind mdl_link_ctrl mdl_link_ctrl_monitor #(.DATA_W(DATA_W))
    i_mdl_link_ctrl_monitor (.mclk(mclk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sample_valid(sample_valid),
    .wakeup_mode(wakeup_mode), .irq_pin_first(irq_pin_first),
    .irq_pin_second(irq_pin_second));

// [verification/mdl_host_model.sv]
module mdl_host_model
    import mdl_pkg::*;
(
    input wire logic mclk,
    input wire logic avs_waitrequest,
    input wire logic [31:0] avs_readdata,
    output logic [ADDR_W-1:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
    end
    // host runs one read or write per call and holds it until waitrequest drops
    task automatic xfer(input logic [4:0] a, input logic rd,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge mclk);
        avs_address <= a;
        avs_read <= rd;
        avs_write <= ~rd;
        avs_writedata <= d;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // released data goes stale on purpose
        avs_writedata <= ~d;
    endtask : xfer
endmodule : mdl_host_model

// [verification/mdl_link_ctrl_tb_top.sv]
module mdl_link_ctrl_tb_top
    import mdl_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk;
    logic rst_n;
    logic [ADDR_W-1:0] adr;
    logic rd_s;
    logic wr_s;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic wait_s;
    logic sample_valid;
    logic signed [11:0] sample_data;
    logic wakeup_mode;
    logic pin1;
    logic pin2;
    int bad_count = 0;
    int checked = 0;
    mdl_link_ctrl #(.DATA_W(12)) i_mdl_link_ctrl (.mclk(mclk), .rst_n(rst_n),
        .avs_address(adr), .avs_read(rd_s), .avs_write(wr_s),
        .avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wait_s),
        .sample_valid(sample_valid), .sample_data(sample_data),
        .wakeup_mode(wakeup_mode), .irq_pin_first(pin1),
        .irq_pin_second(pin2));
    mdl_host_model i_mdl_host_model (.mclk(mclk), .avs_waitrequest(wait_s),
        .avs_readdata(rdat), .avs_address(adr), .avs_read(rd_s),
        .avs_write(wr_s), .avs_writedata(wdat));
    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        i_mdl_host_model.xfer(a, 1'b0, d, q);
    endtask : wr
    task automatic rdc(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] q;
        i_mdl_host_model.xfer(a, 1'b1, 32'h0, q);
        chk(q, e);
    endtask : rdc
    // {wakeup_mode, second pin, first pin}
    task automatic outs(input logic [31:0] e);
        @(negedge mclk);
        chk({29'h0, wakeup_mode, pin2, pin1}, e);
    endtask : outs
    task automatic smp(input int n, input logic [11:0] v);
        repeat (n) begin
            @(posedge mclk);
            sample_valid <= 1'b1;
            sample_data <= v;
        end
        @(posedge mclk);
        sample_valid <= 1'b0;
        sample_data <= ~v;
    endtask : smp
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        rdc(OFS_CTRL, 32'h0);
        rdc(OFS_ACT_TIME, 32'h1);
        rdc(OFS_INACT_TIME, 32'h1);
        wr(OFS_IRQ_MAP, 32'h77);
        smp(1, 12'h064);
        smp(3, 12'h000);
        outs(32'h0);
        wr(OFS_STATUS, 32'hF);
        rdc(OFS_STATUS, 32'h0);
    endtask : t_reset
    task automatic t_default();
        wr(OFS_ACT_THR, 32'hA);
        wr(OFS_INACT_THR, 32'h5);
        wr(OFS_INACT_TIME, 32'h2);
        wr(OFS_IRQ_MAP, 32'h21);
        wr(OFS_CTRL, 32'h13);
        smp(1, 12'h000);
        smp(1, 12'h064);
        smp(1, 12'h000);
        outs(32'h1);
        smp(1, 12'h000);
        outs(32'h3);
        rdc(OFS_STATUS, 32'h3);
        outs(32'h0);
    endtask : t_default
    task automatic t_linked();
        wr(OFS_CTRL, 32'h0);
        wr(OFS_IRQ_MAP, 32'h14);
        wr(OFS_CTRL, 32'h17);
        smp(3, 12'h000);
        outs(32'h0);
        rdc(OFS_STATUS, 32'h0);
        smp(1, 12'h064);
        outs(32'h3);
        smp(2, 12'h000);
        outs(32'h3);
        rdc(OFS_STATUS, 32'h5);
        smp(2, 12'h000);
        outs(32'h4);
        wr(OFS_ACT_TIME, 32'h3);
        smp(1, 12'h064);
        outs(32'h4);
        rdc(OFS_STATUS, 32'hA);
        smp(1, 12'h064);
        outs(32'h3);
    endtask : t_linked
    task automatic t_loop();
        wr(OFS_CTRL, 32'h0);
        wr(OFS_ACT_TIME, 32'h1);
        wr(OFS_IRQ_MAP, 32'h44);
        wr(OFS_CTRL, 32'h1F);
        smp(2, 12'h000);
        outs(32'h0);
        smp(1, 12'h064);
        outs(32'h3);
        smp(2, 12'h000);
        outs(32'h4);
        smp(1, 12'h064);
        outs(32'h3);
        rdc(OFS_STATUS, 32'h5);
    endtask : t_loop
    // referenced linked mode: a stale reference would flag the last sample
    task automatic t_refer();
        wr(OFS_CTRL, 32'h0);
        wr(OFS_IRQ_MAP, 32'h21);
        wr(OFS_CTRL, 32'h67);
        smp(1, 12'h100);
        rdc(OFS_REF, 32'h100);
        smp(1, 12'h108);
        outs(32'h0);
        smp(1, 12'h120);
        outs(32'h1);
        rdc(OFS_STATUS, 32'h5);
        smp(2, 12'h102);
        outs(32'h2);
        rdc(OFS_STATUS, 32'h2);
        smp(1, 12'h200);
        rdc(OFS_REF, 32'h200);
        smp(1, 12'h1F8);
        outs(32'h0);
    endtask : t_refer
    task automatic final_report();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // generous: the whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        final_report();
    end
    initial begin
        rst_n = 1'b0;
        sample_valid = 1'b0;
        sample_data = 12'h000;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_default();
        t_linked();
        t_loop();
        t_refer();
        final_report();
    end
endmodule : mdl_link_ctrl_tb_top
